// ### logic/process_display_limit_tare_logic.sv
// Purpose: value path of a panel meter: filter, round, tare, four limits,
//          analog scaling, control inputs, printer suffix, code lock
// Assumes: all inputs synchronous to clk_i; samples arrive as strobes
// Notes:   all state lives in one struct, two comb and one ff process

`timescale 1ns/1ps
`default_nettype none

module process_display_limit_tare_logic #(
    parameter logic [26:0] TICK_CYCLES =
        27'(proc_pkg::CLK_HZ * proc_pkg::TICK_S),
    parameter logic [26:0] HOLD_CYCLES =
        27'(proc_pkg::CLK_HZ * proc_pkg::HOLD_S)
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          sample_valid_i,
    input  wire logic signed [19:0]            raw_value_i,
    input  wire logic [3:0]                    filt_strength_i,
    input  wire proc_pkg::round_t              round_i,
    input  wire proc_pkg::tare_function_select_t tare_function_select_i,
    input  wire logic                          tare_key_i,
    input  wire logic                          tare_save_i,
    input  wire logic signed [19:0]            tare_val_i,
    input  wire logic                          confirm_key_i,
    input  wire logic                          shift_key_i,
    input  wire logic                          up_key_i,
    input  wire logic [2:0]                    ctrl_i,
    input  wire logic [2:0][3:0]               ctrl_fn_i,
    input  wire proc_pkg::setp_wr_t            setp_i,
    input  wire proc_pkg::lim_cfg_t [3:0]      lim_cfg_i,
    input  wire logic                          two_outputs_i,
    input  wire logic [1:0]                    base_colour_i,
    input  wire logic signed [19:0]            aout_min_i,
    input  wire logic signed [19:0]            aout_max_i,
    input  wire logic                          print_req_i,
    input  wire logic                          print_ts_on_i,
    input  wire logic                          lock_on_i,
    input  wire logic                          lock_all_i,
    input  wire logic [7:0]                    lock_flags_i,
    input  wire logic [2:0]                    module_sel_i,
    input  wire logic                          code_wr_i,
    input  wire logic [15:0]                   code_new_i,
    output logic signed [19:0]                 disp_o,
    output logic                               tare_led_o,
    output logic [3:0]                         relay_o,
    output logic [3:0]                         lim_visible_o,
    output logic [1:0]                         colour_o,
    output logic [15:0]                        analog_o,
    output logic [12:0]                        ctrl_act_o,
    output logic [2:0]                         keys_o,
    output logic [7:0]                         print_byte_o,
    output logic                               print_valid_o,
    output logic [15:0]                        code_o,
    output logic                               code_entry_o,
    output logic                               locked_prompt_o,
    output logic                               edit_en_o
);
    import proc_pkg::*;

    state_t             s;
    state_t             n;
    logic               tick;
    logic [12:0]        act;
    logic [2:0]         emu;
    logic               tp;
    logic               tclr;
    logic               trst;
    logic               hold_act;
    logic signed [20:0] diff;
    logic [3:0]         fshift;
    logic signed [19:0] live_net;
    logic signed [21:0] cv;
    logic signed [21:0] th;
    logic signed [21:0] hy;
    logic [3:0]         raw_now;
    logic [3:0]         present;
    logic [6:0]         dly;
    logic signed [20:0] a_span;
    logic signed [20:0] a_off;
    logic [36:0]        a_num;

    // rounds magnitude so negative values round symmetrically
    function automatic logic signed [19:0] round_step(
        input logic signed [19:0] v,
        input round_t             sel
    );
        logic [19:0] mag;
        logic [19:0] step;
        logic [19:0] r;
        step = (sel == ROUND_5) ? 20'h00005 :
               (sel == ROUND_10) ? 20'h0000A : 20'h00001;
        mag  = v[19] ? 20'(-v) : 20'(v);
        r    = 20'(((mag + (step >> 1)) / step) * step);
        return v[19] ? $signed(20'(-r)) : $signed(r);
    endfunction

    function automatic logic in_range(input logic signed [21:0] v);
        return (v >= LIM_MIN) && (v <= LIM_MAX);
    endfunction

    // timer base, control input decode and key emulation
    always_comb begin
        tick = (s.sec_cnt == TICK_CYCLES - 27'h1);
        act  = '0;
        emu  = '0;
        for (int i = 0; i < 3; i++) begin
            if (ctrl_fn_i[i] <= FN_LAST) begin
                if (FN_EDGE[ctrl_fn_i[i]] && s.ctrl_q[i] && !ctrl_i[i]) begin
                    act[ctrl_fn_i[i]] = 1'b1;
                end
                if (FN_LEVEL[ctrl_fn_i[i]] && !ctrl_i[i]) begin
                    act[ctrl_fn_i[i]] = 1'b1;
                end
            end
            emu[i] = (ctrl_fn_i[i] == FN_KEYB) && !ctrl_i[i];
        end
        hold_act = act[FN_HOLD];
        trst     = act[FN_TRST];
        tp = (tare_key_i && !s.tare_key_q &&
              tare_function_select_i == TARE_BUTTON) || act[FN_TARE];
        tclr = tare_key_i && tare_function_select_i == TARE_BUTTON &&
               s.hold_tare == HOLD_CYCLES - 27'h1;
        fshift   = (filt_strength_i > FILT_MAX) ? FILT_MAX : filt_strength_i;
        diff     = 21'(raw_value_i) - 21'($signed(s.filt));
        live_net = round_step(20'($signed(s.filt) - $signed(s.tare)),
                              round_i);
    end

    // next state; last assignment wins so clears sit after sets
    always_comb begin
        n            = s;
        n.sec_cnt    = tick ? '0 : s.sec_cnt + 27'h1;
        n.ctrl_q     = ctrl_i;
        n.ctrl_act   = act;
        n.keys       = {confirm_key_i | emu[0], shift_key_i | emu[1],
                        up_key_i | emu[2]};
        n.tare_key_q = tare_key_i;
        n.code_entry = 1'b0;
        n.pr_valid   = 1'b0;
        cv  = '0;
        th  = '0;
        hy  = '0;
        dly = '0;
        raw_now = '0;
        present = '0;

        // hold counters restart on release, saturate while held
        if (!tare_key_i) begin
            n.hold_tare = '0;
        end else if (s.hold_tare != HOLD_CYCLES) begin
            n.hold_tare = s.hold_tare + 27'h1;
        end
        if (!n.keys[2]) begin
            n.hold_conf = '0;
        end else if (s.hold_conf != HOLD_CYCLES) begin
            n.hold_conf = s.hold_conf + 27'h1;
        end
        n.code_entry = n.keys[2] && s.hold_conf == HOLD_CYCLES - 27'h1;

        // sample path; filter uses arithmetic shift, so small positive
        // residues below 2^strength are not chased, a deliberate cheapness
        if (sample_valid_i) begin
            if (fshift == 4'h0) begin
                n.filt = raw_value_i;
            end else begin
                n.filt = 20'($signed(s.filt) + (diff >>> fshift));
            end
            if (!hold_act) begin
                if (s.show_tare) begin
                    n.show_tare = 1'b0;
                end else begin
                    n.disp = live_net;
                end
            end
        end

        // tare handling, clears take priority over stores
        if (tare_function_select_i == TARE_ENTERED && tare_save_i) begin
            n.tare     = tare_val_i;
            n.tare_led = (tare_val_i != '0);
        end
        if (tp) begin
            n.tare     = s.filt;
            n.disp     = '0;
            n.tare_led = 1'b1;
        end
        if (tclr) begin
            n.tare     = '0;
            n.tare_led = 1'b0;
        end
        if (trst) begin
            n.disp      = s.tare;
            n.show_tare = 1'b1;
            n.tare      = '0;
            n.tare_led  = 1'b0;
        end

        // setpoint writes refused when out of range or absent
        if (setp_i.wr && in_range(22'(setp_i.val)) &&
            !(two_outputs_i && setp_i.idx[1])) begin
            n.thr[setp_i.idx] = setp_i.val;
        end

        // relays evaluate live values; colour compares the shown display s.disp, frozen while held
        n.colour = base_colour_i;
        for (int i = 0; i < 4; i++) begin
            present[i] = !(two_outputs_i && i >= 2);
            cv = lim_cfg_i[i].gross ?
                 22'(live_net) + 22'($signed(s.tare)) : 22'(live_net);
            th = 22'($signed(s.thr[i]));
            hy = 22'($signed({1'b0, lim_cfg_i[i].amount}));
            raw_now[i] = lim_cfg_i[i].high ? (cv >= th) : (cv <= th);
            dly = (lim_cfg_i[i].amount > 14'(DELAY_MAX_S)) ?
                  DELAY_MAX_S : lim_cfg_i[i].amount[6:0];
            n.raw_q[i]   = raw_now[i];
            n.visible[i] = lim_cfg_i[i].en && present[i];
            if (!lim_cfg_i[i].en || !present[i]) begin
                n.relay[i]   = 1'b0;
                n.lim_cnt[i] = '0;
            end else if (lim_cfg_i[i].mode == HYSTERESIS_OPERATING_MODE) begin
                if (s.relay[i]) begin
                    n.relay[i] = lim_cfg_i[i].high ? (cv >= th - hy)
                                                   : (cv <= th + hy);
                end else begin
                    n.relay[i] = raw_now[i];
                end
                n.lim_cnt[i] = '0;
            end else begin
                // delay counts whole ticks; phase gives up to 1 s early
                if (raw_now[i] == s.relay[i] || raw_now[i] != s.raw_q[i]) begin
                    n.lim_cnt[i] = '0;
                end else if (s.lim_cnt[i] >= dly) begin
                    n.relay[i]   = raw_now[i];
                    n.lim_cnt[i] = '0;
                end else if (tick) begin
                    n.lim_cnt[i] = s.lim_cnt[i] + 7'h01;
                end
            end
            if (lim_cfg_i[i].en && present[i] && lim_cfg_i[i].colour != 2'b00
                && $signed(s.disp) >= $signed(s.thr[i])) begin
                n.colour = lim_cfg_i[i].colour;
            end
        end

        // analog output, clamped at both end points
        a_span = 21'(aout_max_i) - 21'(aout_min_i);
        a_off  = 21'(live_net) - 21'(aout_min_i);
        a_num  = 37'(a_off) * 37'(AOUT_FS);
        if (a_span <= 0 || a_off <= 0) begin
            n.analog = '0;
        end else if (a_off >= a_span) begin
            n.analog = AOUT_FS;
        end else begin
            n.analog = 16'(a_num / 37'(a_span));
        end

        // printer suffix, one byte per cycle, printer always ready
        case (s.pr_st)
            PR_IDLE: begin
                if (print_req_i && print_ts_on_i) begin
                    n.pr_byte  = ESC_CHR;
                    n.pr_valid = 1'b1;
                    n.pr_st    = PR_H;
                end
            end
            PR_H: begin
                n.pr_byte  = H_CHR;
                n.pr_valid = 1'b1;
                n.pr_st    = PR_IDLE;
            end
            default: n.pr_st = PR_IDLE;
        endcase

        // code lock and code storage
        n.locked = lock_on_i && (lock_all_i || lock_flags_i[module_sel_i]);
        if (code_wr_i) begin
            n.code = code_new_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s      <= '0;
            s.code <= CODE_RST;
        end else begin
            s <= n;
        end
    end

    // outputs are struct fields, hence from flops; edit_en_o through one inverter
    assign disp_o          = s.disp;
    assign tare_led_o      = s.tare_led;
    assign relay_o         = s.relay;
    assign lim_visible_o   = s.visible;
    assign colour_o        = s.colour;
    assign analog_o        = s.analog;
    assign ctrl_act_o      = s.ctrl_act;
    assign keys_o          = s.keys;
    assign print_byte_o    = s.pr_byte;
    assign print_valid_o   = s.pr_valid;
    assign code_o          = s.code;
    assign code_entry_o    = s.code_entry;
    assign locked_prompt_o = s.locked;
    assign edit_en_o       = !s.locked;

    // checks on the value path, limits, control inputs, printer and lock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_filter_bypass: assert property (sample_valid_i && fshift == 4'h0
        |=> $signed(s.filt) == $past(raw_value_i))
        else $error("filter zero did not pass sample through");
    a_round_five: assert property (sample_valid_i && !hold_act &&
        !s.show_tare && !tp && !trst && round_i == ROUND_5
        |=> ($signed(s.disp) % 5) == 0)
        else $error("shown value not a multiple of five");
    a_tare_press: assert property (tp && !tclr && !trst
        |=> s.tare == $past(s.filt) && s.disp == '0 && tare_led_o)
        else $error("tare press did not store offset");
    a_tare_hold: assert property (tclr && !tp
        |=> s.tare == '0 && !tare_led_o)
        else $error("tare hold did not clear offset");
    a_lim_disabled: assert property (!lim_cfg_i[0].en
        |=> !relay_o[0] && !lim_visible_o[0])
        else $error("disabled limit output active");
    a_two_outputs: assert property (two_outputs_i |=> relay_o[3:2] == 2'b00)
        else $error("absent limit output active");
    a_delay_restart: assert property (lim_cfg_i[0].en &&
        lim_cfg_i[0].mode == DELAY_OPERATING_MODE && raw_now[0] != s.raw_q[0]
        |=> relay_o[0] == $past(relay_o[0]) && s.lim_cnt[0] == 7'h00)
        else $error("delay output switched on a fresh change");
    a_hyst_on: assert property (lim_cfg_i[0].en &&
        lim_cfg_i[0].mode == HYSTERESIS_OPERATING_MODE && raw_now[0]
        |=> relay_o[0])
        else $error("hysteresis delayed switch on");
    a_thr_range: assert property (in_range(22'($signed(s.thr[0]))) &&
        in_range(22'($signed(s.thr[3]))))
        else $error("threshold outside accepted range");
    a_edge_pulse: assert property (s.ctrl_act[FN_TARE]
        |=> !s.ctrl_act[FN_TARE])
        else $error("edge function held longer than one cycle");
    a_print_suffix: assert property (print_req_i && print_ts_on_i &&
        s.pr_st == PR_IDLE |=> print_valid_o && print_byte_o == ESC_CHR
        ##1 print_valid_o && print_byte_o == H_CHR)
        else $error("escape-H suffix not sent");
    a_lock_all: assert property (lock_on_i && lock_all_i
        |=> locked_prompt_o && !edit_en_o)
        else $error("full lock not applied");

    c_tare_press:  cover property (tp ##1 tare_led_o);
    c_relay_delay: cover property (lim_cfg_i[1].mode == DELAY_OPERATING_MODE
        && $rose(relay_o[1]));
    c_print:       cover property (print_valid_o ##1 print_valid_o);
    c_code_entry:  cover property (code_entry_o);

endmodule

`default_nettype wire

// ### shared/proc_pkg.sv
// Purpose: shared constants and carriers for the panel meter value logic
// Assumes: 40 MHz single clock, display values as 20-bit two's complement
// Notes:   counts above 4096 cycles are top-level parameters

`default_nettype none

package proc_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_S = 1;                  // delay timer resolution, s
    localparam int HOLD_S = 3;                  // key hold time, s
    localparam int CNT_W  = 27;

    localparam int V_W = 20;
    localparam logic signed [21:0] LIM_MAX = 22'sh004E1F;  // +19999
    localparam logic signed [21:0] LIM_MIN = -22'sh004E1F; // -19999
    localparam logic [6:0]  DELAY_MAX_S = 7'h63;            // 99 s
    localparam logic [3:0]  FILT_MAX    = 4'h9;
    localparam logic [15:0] CODE_RST    = 16'h0000;
    localparam logic [15:0] AOUT_FS     = 16'hFFFF;
    localparam logic [7:0]  ESC_CHR     = 8'h1B;
    localparam logic [7:0]  H_CHR       = 8'h48;

    // control input function codes
    localparam logic [3:0]  FN_TARE  = 4'h1;
    localparam logic [3:0]  FN_TRST  = 4'h2;
    localparam logic [3:0]  FN_HOLD  = 4'h6;
    localparam logic [3:0]  FN_KEYB  = 4'hB;
    localparam logic [3:0]  FN_LAST  = 4'hC;
    localparam logic [12:0] FN_EDGE  = 13'h022E;   // codes 1,2,3,5,9
    localparam logic [12:0] FN_LEVEL = 13'h0DD0;   // codes 4,6,7,8,10,11

    typedef enum logic [1:0] {
        ROUND_1  = 2'b00,
        ROUND_5  = 2'b01,
        ROUND_10 = 2'b10
    } round_t;

    typedef enum logic {
        TARE_BUTTON  = 1'b0,
        TARE_ENTERED = 1'b1
    } tare_function_select_t;

    typedef enum logic {
        DELAY_OPERATING_MODE      = 1'b0,
        HYSTERESIS_OPERATING_MODE = 1'b1
    } lim_mode_t;

    typedef enum logic {
        PR_IDLE = 1'b0,
        PR_H    = 1'b1
    } print_state_t;

    typedef struct packed {
        logic        en;
        logic        gross;     // compare net + tare
        logic        high;      // 1: >= limit, 0: <= limit
        lim_mode_t   mode;
        logic [1:0]  colour;    // 0: no colour change
        logic [13:0] amount;    // delay s or hysteresis units
    } lim_cfg_t;

    typedef struct packed {
        logic                  wr;
        logic [1:0]            idx;
        logic signed [V_W-1:0] val;
    } setp_wr_t;

    typedef struct packed {
        logic [V_W-1:0]       filt;
        logic [V_W-1:0]       tare;
        logic [V_W-1:0]       disp;
        logic                 tare_led;
        logic                 show_tare;
        logic                 tare_key_q;
        logic [CNT_W-1:0]     hold_tare;
        logic [CNT_W-1:0]     hold_conf;
        logic [CNT_W-1:0]     sec_cnt;
        logic [2:0]           ctrl_q;
        logic [12:0]          ctrl_act;
        logic [2:0]           keys;       // confirm, shift, up
        logic [3:0][V_W-1:0]  thr;
        logic [3:0]           relay;
        logic [3:0]           raw_q;
        logic [3:0][6:0]      lim_cnt;
        logic [3:0]           visible;
        logic [1:0]           colour;
        logic [15:0]          analog;
        print_state_t         pr_st;
        logic [7:0]           pr_byte;
        logic                 pr_valid;
        logic [15:0]          code;
        logic                 code_entry;
        logic                 locked;
    } state_t;

endpackage

`default_nettype wire

// ### test/ctrl_lines.sv
// Purpose: field switch model driving the three control lines
// Assumes: lines idle high through pull-ups, active low
// Notes:   the bench chooses which lines are pulled and for how long
`timescale 1ns/1ps
`default_nettype none

module ctrl_lines (
    input  wire logic [2:0] pull_i,
    output logic [2:0]      ctrl_o
);
    // a released line returns to its pull-up level, never floats
    assign ctrl_o = ~pull_i;
endmodule

`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench for the panel meter value logic
// Assumes: 25 ns clock, tick of 10 and hold of 20 cycles
// Notes:   each scenario drives and judges before it returns
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import proc_pkg::*;
    localparam int HOLD = 20;
    logic                 clk_i, rst_i, smp, tkey, preq, pts, lon, lall;
    logic                 tsave, two, cfm, cwr, cent, edit;
    logic signed [19:0]   raw, disp, tval;
    logic [3:0]           relay, vis, fs;
    logic [2:0]           pull, ctrl, msel, keys;
    logic [1:0]           colour;
    logic [15:0]          aout, cnew, code;
    tare_function_select_t tsel;
    logic [2:0][3:0]      fn;
    round_t               rnd;
    setp_wr_t             sp;
    lim_cfg_t [3:0]       cfg;
    logic [7:0]           lflg, pbyte;
    logic [12:0]          act;
    logic                 led, pval, lockp;
    logic [19:0]          v;
    int                   errors, n_checks;

    ctrl_lines i_ctrl_lines (.pull_i(pull), .ctrl_o(ctrl));

    process_display_limit_tare_logic #(.TICK_CYCLES(27'd10),
        .HOLD_CYCLES(27'd20)) i_process_display_limit_tare_logic (
        .clk_i(clk_i), .rst_i(rst_i), .sample_valid_i(smp),
        .raw_value_i(raw), .filt_strength_i(fs), .round_i(rnd),
        .tare_function_select_i(tsel), .tare_key_i(tkey),
        .tare_save_i(tsave), .tare_val_i(tval),
        .confirm_key_i(cfm), .shift_key_i(1'b0), .up_key_i(1'b0),
        .ctrl_i(ctrl), .ctrl_fn_i(fn), .setp_i(sp), .lim_cfg_i(cfg),
        .two_outputs_i(two), .base_colour_i(2'h0),
        .aout_min_i(-20'sh04E1F), .aout_max_i(20'sh04E1F),
        .print_req_i(preq), .print_ts_on_i(pts), .lock_on_i(lon),
        .lock_all_i(lall), .lock_flags_i(lflg), .module_sel_i(msel),
        .code_wr_i(cwr), .code_new_i(cnew), .disp_o(disp),
        .tare_led_o(led), .relay_o(relay), .lim_visible_o(vis),
        .colour_o(colour), .analog_o(aout), .ctrl_act_o(act), .keys_o(keys),
        .print_byte_o(pbyte), .print_valid_o(pval), .code_o(code),
        .code_entry_o(cent), .locked_prompt_o(lockp), .edit_en_o(edit));

    // inputs always move 1 ns after an edge, never on it
    task automatic step(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // two strobes: the second publishes the first one's filtered value
    task automatic feed(logic signed [19:0] x);
        raw = x;
        smp = 1'b1;
        step(2);
        smp = 1'b0;
        step(3);
    endtask

    task automatic t_sample();
        rnd = ROUND_10;
        feed(20'sh0000C);
        chk("disp step 10", 20'h0000A, disp);
        rnd = ROUND_1;
        feed(20'sh00064);
        chk("disp unfiltered", 20'h00064, disp);
        chk("analog", 20'h080A3, 20'(aout));
        fs = 4'h1;
        feed(20'sh000C8);
        chk("disp filtered", 20'h00096, disp);
        fs = 4'h0;
        feed(20'sh00064);
    endtask

    task automatic t_tare();
        tkey = 1'b1;
        step(3);
        chk("tare disp", 20'h00000, disp);
        chk("tare lamp", 20'h00001, 20'(led));
        step(HOLD + 3);
        chk("lamp after hold", 20'h00000, 20'(led));
        tkey = 1'b0;
    endtask

    // entered tare of 30 against a live value of 100, then cleared
    task automatic t_entered();
        tsel = TARE_ENTERED;
        tval = 20'sh0001E;
        tsave = 1'b1;
        step(1);
        tsave = 1'b0;
        chk("entered lamp", 20'h00001, 20'(led));
        feed(20'sh00064);
        chk("entered net", 20'h00046, disp);
        tval = 20'sh00000;
        tsave = 1'b1;
        step(1);
        tsave = 1'b0;
        tsel = TARE_BUTTON;
    endtask

    // live net is 100 against a limit of 50
    task automatic t_limit();
        sp = '{wr: 1'b1, idx: 2'h0, val: 20'sh00032};
        cfg[0] = '{1'b1, 1'b0, 1'b1, HYSTERESIS_OPERATING_MODE, 2'h0, 14'h0};
        step(1);
        sp.wr = 1'b0;
        step(4);
        chk("high sense", 20'h00001, 20'(relay));
        cfg[0].high = 1'b0;
        step(4);
        chk("low sense", 20'h00000, 20'(relay));
        cfg[0] = '{1'b1, 1'b0, 1'b1, DELAY_OPERATING_MODE, 2'h0, 14'h3};
        step(4);
        chk("delay early", 20'h00000, 20'(relay));
        step(45);
        chk("delay late", 20'h00001, 20'(relay));
        cfg[0].en = 1'b0;
        step(4);
        chk("disabled", 20'h00000, 20'(relay));
    endtask

    // refused writes leave thresholds at 0, below the live net of 100
    task automatic t_two();
        two = 1'b1;
        cfg[2] = '{1'b1, 1'b0, 1'b1, HYSTERESIS_OPERATING_MODE, 2'h2, 14'h0};
        sp = '{wr: 1'b1, idx: 2'h2, val: 20'sh000C8};
        step(1);
        sp = '{wr: 1'b1, idx: 2'h1, val: 20'sh04E20};
        step(1);
        sp.wr = 1'b0;
        step(3);
        chk("absent output", 20'h00000, 20'(relay));
        chk("absent hidden", 20'h00000, 20'(vis));
        chk("absent colour", 20'h00000, 20'(colour));
        two = 1'b0;
        cfg[1] = cfg[2];
        step(4);
        chk("refused writes", 20'h00006, 20'(relay));
        chk("shown limits", 20'h00006, 20'(vis));
        chk("limit colour", 20'h00002, 20'(colour));
        cfg = '0;
    endtask

    // one edge code and one level code, the level one being hold
    task automatic t_ctrl();
        feed(20'sh00064);
        fn = {4'h0, FN_HOLD, 4'h3};
        v = 20'h0;
        pull = 3'h1;
        repeat (6) begin
            step(1);
            v = v + 20'(act[3]);
        end
        chk("edge pulses", 20'h00001, v);
        pull = 3'h2;
        step(3);
        chk("level active", 20'h00001, 20'(act[6]));
        feed(20'sh000C8);
        chk("held disp", 20'h00064, disp);
        fn = {4'h0, 4'h0, FN_KEYB};
        pull = 3'h1;
        step(2);
        chk("emulated confirm", 20'h00004, 20'(keys));
        pull = 3'h0;
    endtask

    task automatic t_print();
        pts = 1'b1;
        preq = 1'b1;
        v = 20'h0;
        step(1);
        preq = 1'b0;
        repeat (4) begin
            if (pval === 1'b1) v = {v[11:0], pbyte};
            step(1);
        end
        chk("print suffix", 20'h01B48, v);
    endtask

    task automatic t_lock();
        lon = 1'b1;
        lall = 1'b1;
        step(2);
        chk("lock all", 20'h00001, 20'(lockp));
        chk("edit blocked", 20'h00000, 20'(edit));
        lall = 1'b0;
        lflg = 8'h04;
        msel = 3'h2;
        step(2);
        chk("flagged", 20'h00001, 20'(lockp));
        msel = 3'h1;
        step(2);
        chk("unflagged", 20'h00000, 20'(lockp));
        chk("edit allowed", 20'h00001, 20'(edit));
    endtask

    // code store, then confirm held: entry pulse after exactly HOLD cycles
    task automatic t_code();
        chk("code reset", 20'h00000, 20'(code));
        cwr = 1'b1;
        cnew = 16'h1234;
        step(1);
        cwr = 1'b0;
        chk("code stored", 20'h01234, 20'(code));
        cfm = 1'b1;
        step(HOLD - 1);
        chk("entry early", 20'h00000, 20'(cent));
        step(1);
        chk("entry on time", 20'h00001, 20'(cent));
        step(1);
        chk("entry pulse", 20'h00000, 20'(cent));
        cfm = 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // whole run is under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        give_verdict();
    end

    initial begin
        {smp, tkey, preq, pts, lon, lall} = 6'h0;
        {pull, msel, fn, lflg} = '0;
        {tsave, two, cfm, cwr} = 4'h0;
        fs = 4'h0;
        tsel = TARE_BUTTON;
        tval = 20'sh00000;
        cnew = 16'h0000;
        raw = 20'sh0;
        rnd = ROUND_1;
        sp = '0;
        cfg = '0;
        rst_i = 1'b1;
        step(10);
        rst_i = 1'b0;
        t_sample();
        t_tare();
        t_entered();
        t_limit();
        t_two();
        t_ctrl();
        t_print();
        t_lock();
        t_code();
        give_verdict();
    end
endmodule

`default_nettype wire
